// File: hdl/fbrc_top.sv
// Purpose: burst read sequencer and configuration word of a flash
// Assumes: host pins asynchronous to REF_CLK; array port synchronous
// Notes: all host pins pass a two-stage synchroniser
`include "fbrc_map.svh"

module fbrc_top
  import fbrc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // host control pins
  input wire logic CE_N,
  input wire logic ADDRESS_LATCH_STROBE_N,
  input wire logic OE_N,
  input wire logic BUS_X32,
  input wire logic [`FBRC_ADDR_W-1:0] ADDR,
  // host command port
  input wire logic CMD_STB,
  input wire fbrc_pkg::fbrc_cmd_t CMD_CODE,
  input wire fbrc_pkg::fbrc_word_t CMD_DATA,
  // internal algorithm status
  input wire logic ALGO_BUSY,
  // data and flag pins
  output logic [`FBRC_DQ_W-1:0] DQ_O,
  output logic DQ_OE,
  output logic END_OF_BURST_FLAG_N_O,
  output logic END_OF_BURST_FLAG_OE,
  // array port
  output logic [`FBRC_ADDR_W-1:0] ARRAY_ADDR,
  output logic ARRAY_REQ,
  input wire fbrc_pkg::fbrc_word_t ARRAY_DATA,
  input wire logic ARRAY_VALID,
  output logic ARRAY_READY
);
  import fbrc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] burst_words(input logic [2:0] bl,
                                             input logic x32);
    logic [5:0] n;
    n = 6'h00;
    case (bl)
      3'h1: n = x32 ? 6'h02 : 6'h04;
      3'h2: n = x32 ? 6'h04 : 6'h08;
      3'h3: n = x32 ? 6'h08 : 6'h10;
      3'h4: n = x32 ? 6'h00 : 6'h20;
      default: n = 6'h00;
    endcase
    return n;
  endfunction

  function automatic logic [`FBRC_ADDR_W-1:0] wrap_addr(
    input logic [`FBRC_ADDR_W-1:0] base, input logic [5:0] idx,
    input logic [5:0] len);
    logic [`FBRC_ADDR_W-1:0] mask;
    logic [`FBRC_ADDR_W-1:0] sum;
    mask = {{(`FBRC_ADDR_W-6){1'b0}}, len - 6'h01};
    sum = base + {{(`FBRC_ADDR_W-6){1'b0}}, idx};
    return (base & ~mask) | (sum & mask);
  endfunction

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [`FBRC_PIN_N-1:0] pin_s1_reg;
  logic [`FBRC_PIN_N-1:0] pin_s2_reg;
  logic [`FBRC_ADDR_W-1:0] addr_s1_reg;
  logic [`FBRC_ADDR_W-1:0] addr_s2_reg;
  logic [33:0] cmd_s1_reg;
  logic [33:0] cmd_s2_reg;
  logic adv_n_d_reg;
  logic stb_d_reg;

  always_ff @(posedge REF_CLK)
  begin
    pin_s1_reg <= {CE_N, ADDRESS_LATCH_STROBE_N, OE_N, CMD_STB, BUS_X32,
                   ALGO_BUSY};
    pin_s2_reg <= pin_s1_reg;
    addr_s1_reg <= ADDR;
    addr_s2_reg <= addr_s1_reg;
    cmd_s1_reg <= {CMD_CODE, CMD_DATA};
    cmd_s2_reg <= cmd_s1_reg;
    adv_n_d_reg <= pin_s2_reg[4];
    stb_d_reg <= pin_s2_reg[2];
  end

  wire ce_n_s = pin_s2_reg[5];
  wire adv_n_s = pin_s2_reg[4];
  wire oe_n_s = pin_s2_reg[3];
  wire x32_s = pin_s2_reg[1];
  wire busy_s = pin_s2_reg[0];
  wire cmd_go = pin_s2_reg[2] & ~stb_d_reg;
  wire [1:0] cmd_code_s = cmd_s2_reg[33:32];
  wire [31:0] cmd_data_s = cmd_s2_reg[31:0];
  wire adv_fall = adv_n_d_reg & ~adv_n_s;

  // ----------------------------------------
  // configuration word and command decode
  // ----------------------------------------
  logic [`FBRC_CFG_W-1:0] cfg_reg;
  logic cfg_rd_reg;
  logic cfg_bank_reg;

  // register reached only through commands
  wire cmd_wr = cmd_go & (cmd_code_s == FBRC_CMD_CFG_WR);
  wire cmd_rd = cmd_go & (cmd_code_s == FBRC_CMD_CFG_RD);
  wire cmd_arr = cmd_go & (cmd_code_s == FBRC_CMD_ARRAY);
  wire wr_ok = cmd_wr & ~busy_s;
  wire cfg_rm = cfg_reg[`FBRC_BIT_RM];
  wire [3:0] lat_code = cfg_reg[`FBRC_LAT_HI:`FBRC_LAT_LO];
  wire [3:0] lat_len = lat_code + `FBRC_LAT_ADD;
  wire cfg_eobt = cfg_reg[`FBRC_BIT_EOBT];
  wire cfg_lin = cfg_reg[`FBRC_BIT_ORD];
  wire cfg_rise = cfg_reg[`FBRC_BIT_EDGE];
  wire [5:0] len_cfg = burst_words(cfg_reg[`FBRC_BL_HI:`FBRC_BL_LO],
                                   x32_s);
  // codes giving no length leave async reads only
  wire burst_en = ~cfg_rm & cfg_lin & (len_cfg != 6'h00);
  wire bank_s = addr_s2_reg[`FBRC_ADDR_W-1];

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      cfg_reg <= `FBRC_CFG_RST;
      cfg_rd_reg <= 1'b0;
      cfg_bank_reg <= 1'b0;
    end
    else
    begin
      if (wr_ok)
        cfg_reg <= cmd_data_s[`FBRC_CFG_W-1:0];
      if (cmd_rd)
      begin
        cfg_rd_reg <= 1'b1;
        cfg_bank_reg <= bank_s;
      end
      else if (cmd_arr)
        cfg_rd_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  fbrc_state_t st_reg;
  fbrc_state_t st_next;
  logic [3:0] lat_cnt_reg;
  logic [5:0] word_cnt_reg;
  logic [5:0] fetch_cnt_reg;
  logic [5:0] len_reg;
  logic eobt_reg;
  logic [`FBRC_ADDR_W-1:0] base_reg;

  fbrc_stream_if fill_s ();
  fbrc_stream_if drain_s ();

  // chip select high or a new strobe ends the burst
  wire abort = ce_n_s & (st_reg != FBRC_IDLE);
  wire start = ~ce_n_s & burst_en &
               (((st_reg == FBRC_IDLE) & ~adv_n_s) | adv_fall);
  wire lat_done = (st_reg == FBRC_LAT) & (lat_cnt_reg == 4'h1);
  wire last_word = (word_cnt_reg == len_reg);
  wire step = lat_done | ((st_reg == FBRC_DATA) & ~last_word);
  wire [5:0] word_next = word_cnt_reg + 6'h01;
  wire eob_now = ({1'b0, word_next} + {6'h00, eobt_reg}) >=
                 {1'b0, len_reg};
  wire fetching = (st_reg != FBRC_IDLE) & (fetch_cnt_reg != len_reg);

  // buffer emptied whenever a new burst starts
  fbrc_buf u_buf
  (
    .clk(REF_CLK),
    .rst_n(RST_N & ~start),
    .in_s(fill_s.snk),
    .out_s(drain_s.src)
  );

  assign fill_s.data = ARRAY_DATA;
  assign fill_s.valid = ARRAY_VALID & fetching;
  assign drain_s.ready = step;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      FBRC_IDLE: st_next = FBRC_IDLE;
      FBRC_LAT: st_next = lat_done ? FBRC_DATA : FBRC_LAT;
      FBRC_DATA: st_next = last_word ? FBRC_IDLE : FBRC_DATA;
      default: st_next = FBRC_IDLE;
    endcase
    if (start)
      st_next = FBRC_LAT;
    else if (abort)
      st_next = FBRC_IDLE;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      st_reg <= FBRC_IDLE;
      lat_cnt_reg <= 4'h0;
      word_cnt_reg <= 6'h00;
      fetch_cnt_reg <= 6'h00;
      len_reg <= 6'h00;
      eobt_reg <= 1'b0;
      base_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      if (start)
      begin
        lat_cnt_reg <= lat_len;
        word_cnt_reg <= 6'h00;
        fetch_cnt_reg <= 6'h00;
        len_reg <= len_cfg;
        eobt_reg <= cfg_eobt;
        base_reg <= addr_s2_reg;
      end
      else
      begin
        if (st_reg == FBRC_LAT)
          lat_cnt_reg <= lat_cnt_reg - 4'h1;
        if (step)
          word_cnt_reg <= word_next;
        if (fill_s.valid & fill_s.ready)
          fetch_cnt_reg <= fetch_cnt_reg + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // array port
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      ARRAY_ADDR <= '0;
      ARRAY_REQ <= 1'b0;
      ARRAY_READY <= 1'b0;
    end
    else
    begin
      if (start)
        ARRAY_ADDR <= addr_s2_reg;
      else if (st_reg == FBRC_IDLE)
        ARRAY_ADDR <= addr_s2_reg;
      else
        ARRAY_ADDR <= wrap_addr(base_reg, fetch_cnt_reg +
                     {5'h00, fill_s.valid & fill_s.ready}, len_reg);
      // fetch from the start edge so a two-clock latency is met
      ARRAY_REQ <= start | (fetching & ~abort);
      ARRAY_READY <= fill_s.ready;
    end
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  logic [`FBRC_DQ_W-1:0] dq_reg;
  logic dq_oe_reg;
  logic eob_n_reg;
  logic eob_oe_reg;
  logic [`FBRC_DQ_W-1:0] dq_neg_reg;
  logic dq_oe_neg_reg;
  logic eob_n_neg_reg;
  logic eob_oe_neg_reg;

  wire async_rd = ~ce_n_s & ~oe_n_s & (st_reg == FBRC_IDLE) & ~start;
  wire show_cfg = cfg_rd_reg & (bank_s == cfg_bank_reg);
  wire [`FBRC_DQ_W-1:0] cfg_word = {16'h0000, cfg_reg};
  wire live = (st_next == FBRC_DATA);
  wire drive = ~oe_n_s & ~ce_n_s;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      eob_n_reg <= 1'b1;
      eob_oe_reg <= 1'b0;
    end
    else
    begin
      if (step)
        dq_reg <= drain_s.data;
      else if (async_rd)
        dq_reg <= show_cfg ? cfg_word : ARRAY_DATA;
      if (step)
        eob_n_reg <= ~eob_now;
      else if (!live)
        eob_n_reg <= 1'b1;
      dq_oe_reg <= drive & ((st_next == FBRC_DATA) | step |
                   async_rd);
      eob_oe_reg <= drive & (st_next != FBRC_IDLE) & ~abort;
    end
  end

  // falling edge copy for the half-cycle output option
  always_ff @(negedge REF_CLK)
  begin
    dq_neg_reg <= dq_reg;
    dq_oe_neg_reg <= dq_oe_reg;
    eob_n_neg_reg <= eob_n_reg;
    eob_oe_neg_reg <= eob_oe_reg;
  end

  // flag and data share one launch path
  assign DQ_O = cfg_rise ? dq_reg : dq_neg_reg;
  assign DQ_OE = cfg_rise ? dq_oe_reg : dq_oe_neg_reg;
  assign END_OF_BURST_FLAG_N_O = cfg_rise ? eob_n_reg : eob_n_neg_reg;
  assign END_OF_BURST_FLAG_OE = cfg_rise ? eob_oe_reg : eob_oe_neg_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_eob_last;
    @(posedge REF_CLK) disable iff (!RST_N)
    (step & ~eobt_reg) |=> (eob_n_reg == (word_cnt_reg != len_reg));
  endproperty
  a_eob_last: assert property (p_eob_last)
    else $error("flag not tied to last word");

  property p_eob_early;
    @(posedge REF_CLK) disable iff (!RST_N)
    (step & eobt_reg & (word_next == len_reg - 6'h01)) |=> !eob_n_reg;
  endproperty
  a_eob_early: assert property (p_eob_early)
    else $error("early flag missing");

  property p_eob_float;
    @(posedge REF_CLK) disable iff (!RST_N)
    oe_n_s |=> !eob_oe_reg && !dq_oe_reg;
  endproperty
  a_eob_float: assert property (p_eob_float)
    else $error("outputs driven with gate high");

  property p_lat_len;
    @(posedge REF_CLK) disable iff (!RST_N)
    (start & (lat_len == 4'h2)) ##1 (!start & !abort) [*2]
      |=> st_reg == FBRC_DATA;
  endproperty
  a_lat_len: assert property (p_lat_len)
    else $error("latency of two not honoured");

  property p_wr_busy;
    @(posedge REF_CLK) disable iff (!RST_N)
    (cmd_wr & busy_s) |=> $stable(cfg_reg);
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("write taken while busy");

  property p_upper_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
    (async_rd & show_cfg) |=> dq_reg[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper lines not zero");

  property p_reset;
    @(posedge REF_CLK)
    !RST_N |=> (cfg_reg == `FBRC_CFG_RST) && (st_reg == FBRC_IDLE);
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not restore defaults");

  property p_ce_abort;
    @(posedge REF_CLK) disable iff (!RST_N)
    abort |=> (st_reg == FBRC_IDLE) && !dq_oe_reg && !eob_oe_reg;
  endproperty
  a_ce_abort: assert property (p_ce_abort)
    else $error("burst survived chip deselect");

  property p_async_only;
    @(posedge REF_CLK) disable iff (!RST_N)
    (!burst_en & (st_reg == FBRC_IDLE)) |=> st_reg == FBRC_IDLE;
  endproperty
  a_async_only: assert property (p_async_only)
    else $error("burst in async mode");

  property p_cnt_bound;
    @(posedge REF_CLK) disable iff (!RST_N)
    (st_reg == FBRC_DATA) |-> word_cnt_reg <= len_reg;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("word counter overran");

  c_burst: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    (st_reg == FBRC_DATA) ##1 (st_reg == FBRC_IDLE));
  c_cfg_wr: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_ok);
  c_gate_hi: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    (st_reg == FBRC_DATA) && oe_n_s);
endmodule

// File: hdl/fbrc_map.svh
// Purpose: constants of the burst read configuration block
// Assumes: included by bare name
// Notes: offsets are bit positions in the configuration word
`ifndef FBRC_MAP_SVH
`define FBRC_MAP_SVH
`define FBRC_CFG_RST 16'h9CC4
`define FBRC_CFG_W 16
`define FBRC_BIT_RM 15
`define FBRC_LAT_HI 13
`define FBRC_LAT_LO 10
`define FBRC_BIT_HOLD 9
`define FBRC_BIT_EOBT 8
`define FBRC_BIT_ORD 7
`define FBRC_BIT_EDGE 6
`define FBRC_BL_HI 2
`define FBRC_BL_LO 0
`define FBRC_LAT_ADD 4'h2
`define FBRC_ADDR_W 20
`define FBRC_DQ_W 32
`define FBRC_PIN_N 6
`endif

// File: hdl/fbrc_pkg.sv
// Purpose: types of the burst read configuration block
// Assumes: nothing
// Notes: constants live in fbrc_map.svh
package fbrc_pkg;
  typedef enum logic [1:0] {
    FBRC_IDLE = 2'b00,
    FBRC_LAT = 2'b01,
    FBRC_DATA = 2'b10
  } fbrc_state_t;
  typedef enum logic [1:0] {
    FBRC_CMD_NONE = 2'b00,
    FBRC_CMD_CFG_WR = 2'b01,
    FBRC_CMD_CFG_RD = 2'b10,
    FBRC_CMD_ARRAY = 2'b11
  } fbrc_cmd_t;
  typedef logic [31:0] fbrc_word_t;
endpackage

// File: hdl/fbrc_stream_if.sv
// Purpose: valid/ready word stream between block modules
// Assumes: one clock
// Notes: src drives data and valid, snk drives ready
interface fbrc_stream_if;
  import fbrc_pkg::*;
  fbrc_word_t data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// File: hdl/fbrc_buf.sv
// Purpose: two-entry word buffer in the burst data path
// Assumes: synchronous active-low reset
// Notes: full and empty are exact
module fbrc_buf
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // streams
  fbrc_stream_if.snk in_s,
  fbrc_stream_if.src out_s
);
  import fbrc_pkg::*;
  fbrc_word_t mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  wire push = in_s.valid & in_s.ready;
  wire pop = out_s.valid & out_s.ready;
  assign in_s.ready = (cnt_reg != 2'h2);
  assign out_s.valid = (cnt_reg != 2'h0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_s.data;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: tb/fbrc_array_model.sv
// Purpose: array side model answering word fetches of the block
// Assumes: same clock as the block, words are combinational
// Notes: each word holds its own address, so order is visible
`include "fbrc_map.svh"
module fbrc_array_model
  import fbrc_pkg::*;
(
  // clock
  input wire logic clk,
  // array port
  input wire logic [`FBRC_ADDR_W-1:0] addr,
  input wire logic req,
  input wire logic slow,
  output fbrc_pkg::fbrc_word_t data,
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gap_reg = 1'b0;
  // slow mode leaves every second cycle without a word
  always_ff @(posedge clk)
  begin
    gap_reg <= slow & ~gap_reg;
  end
  assign data = {12'h000, addr};
  assign valid = req & ~gap_reg;
endmodule

// File: tb/tb_top.sv
// Purpose: self-checking bench of the burst read sequencer
// Assumes: pins driven at falling edge, two-stage input sync
// Notes: first word found by data enable, latency checked relative
module tb_top;
  import fbrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce_n = 1'b1;
  logic strobe_n = 1'b1;
  logic oe_n = 1'b1;
  logic x32 = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic cmd_stb = 1'b0;
  fbrc_cmd_t cmd_code = FBRC_CMD_NONE;
  fbrc_word_t cmd_data = 32'h00000000;
  logic busy = 1'b0;
  logic slow = 1'b0;
  logic [31:0] dq;
  logic dq_oe, flag_n, flag_oe, arr_req, arr_valid;
  logic [19:0] arr_addr;
  fbrc_word_t arr_data;
  int miscompares = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  fbrc_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .CE_N(ce_n),
    .ADDRESS_LATCH_STROBE_N(strobe_n), .OE_N(oe_n), .BUS_X32(x32),
    .ADDR(addr), .CMD_STB(cmd_stb), .CMD_CODE(cmd_code),
    .CMD_DATA(cmd_data), .ALGO_BUSY(busy), .DQ_O(dq), .DQ_OE(dq_oe),
    .END_OF_BURST_FLAG_N_O(flag_n), .END_OF_BURST_FLAG_OE(flag_oe),
    .ARRAY_ADDR(arr_addr), .ARRAY_REQ(arr_req), .ARRAY_DATA(arr_data),
    .ARRAY_VALID(arr_valid), .ARRAY_READY());
  fbrc_array_model i_array (.clk(clk), .addr(arr_addr), .req(arr_req),
    .slow(slow), .data(arr_data), .valid(arr_valid));
  // ---------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------
  task automatic chk32(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk1(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reserved bits always written as zero
  function automatic logic [15:0] cfg(int lat, logic wc, logic [2:0] bl);
    return {2'b00, 4'(lat), 1'b0, wc, 2'b11, 3'b000, bl};
  endfunction
  task automatic send_cmd(fbrc_cmd_t c, logic [31:0] d, logic [19:0] a);
    @(negedge clk);
    cmd_code = c;
    cmd_data = d;
    addr = a;
    cmd_stb = 1'b1;
    repeat (3) @(negedge clk);
    cmd_stb = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic read_cfg(logic [15:0] exp, logic bank);
    logic [19:0] oth;
    oth = {~bank, 19'h00010};
    send_cmd(FBRC_CMD_CFG_RD, 32'h0, {bank, 19'h0});
    ce_n = 1'b0;
    oe_n = 1'b0;
    addr = {bank, 19'h00010};
    repeat (5) @(negedge clk);
    chk32("cfg read", {16'h0000, exp}, dq);
    chk1("cfg read oe", 1'b1, dq_oe);
    addr = oth;
    repeat (5) @(negedge clk);
    chk32("other bank", {12'h000, oth}, dq);
    ce_n = 1'b1;
    oe_n = 1'b1;
    send_cmd(FBRC_CMD_ARRAY, 32'h0, 20'h0);
  endtask
  task automatic start_burst(logic [19:0] a, output int t);
    @(negedge clk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    addr = a;
    strobe_n = 1'b0;
    @(negedge clk);
    strobe_n = 1'b1;
    t = 1;
    while (dq_oe !== 1'b1 && t < 40)
    begin
      @(negedge clk);
      t++;
    end
    chk1("burst started", 1'b1, dq_oe);
  endtask
  task automatic burst(logic [19:0] a, int n, logic wc, output int t);
    logic [19:0] ea;
    start_burst(a, t);
    for (int i = 0; i < n; i++)
    begin
      ea = 20'((a & ~(n - 1)) | ((a + i) & (n - 1)));
      chk32("burst word", {12'h000, ea}, dq);
      chk1("flag", !(i == n - 1 || (wc && i == n - 2)), flag_n);
      chk1("data oe", 1'b1, dq_oe);
      @(negedge clk);
    end
    chk1("flag oe end", 1'b0, flag_oe);
    chk1("flag idle", 1'b1, flag_n);
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic check_cfg_write();
    busy = 1'b1;
    send_cmd(FBRC_CMD_CFG_WR, 32'hFFFF1204, 20'h0);
    busy = 1'b0;
    read_cfg(16'h9CC4, 1'b0);
    send_cmd(FBRC_CMD_CFG_WR, 32'hABCD8BC2, 20'h0);
    read_cfg(16'h8BC2, 1'b1);
  endtask
  task automatic check_lengths();
    int code, n, t;
    for (int k = 0; k < 7; k++)
    begin
      x32 = (k > 3);
      code = x32 ? k - 3 : k + 1;
      n = (8 << (code - 1)) / (x32 ? 4 : 2);
      send_cmd(FBRC_CMD_CFG_WR, {16'h0, cfg(1, k[0], 3'(code))}, 20'h0);
      burst(20'(20'h00100 + k * 3), n, k[0], t);
    end
    x32 = 1'b0;
  endtask
  task automatic check_latency();
    int t, t0;
    t0 = 0;
    for (int lat = 0; lat < 8; lat++)
    begin
      send_cmd(FBRC_CMD_CFG_WR, {16'h0, cfg(lat, 1'b0, 3'b001)}, 20'h0);
      burst(20'h00042, 4, 1'b0, t);
      if (lat == 0)
        t0 = t;
      else
        chk32("latency", 32'(t0 + lat), 32'(t));
    end
  endtask
  task automatic check_async();
    logic [15:0] av [4] = '{16'h84C1, 16'h04C0, 16'h04C5, 16'h04C6};
    logic seen;
    for (int k = 0; k < 4; k++)
    begin
      send_cmd(FBRC_CMD_CFG_WR, {16'h0, av[k]}, 20'h0);
      ce_n = 1'b0;
      oe_n = 1'b0;
      addr = 20'(20'h00200 + k);
      strobe_n = 1'b0;
      @(negedge clk);
      strobe_n = 1'b1;
      seen = 1'b0;
      repeat (12)
      begin
        @(negedge clk);
        seen = seen | (flag_oe === 1'b1);
      end
      chk1("no burst", 1'b0, seen);
      chk32("async word", {12'h000, addr}, dq);
      ce_n = 1'b1;
      oe_n = 1'b1;
    end
  endtask
  task automatic check_abort();
    int t;
    send_cmd(FBRC_CMD_CFG_WR, {16'h0, cfg(1, 1'b0, 3'b100)}, 20'h0);
    start_burst(20'h00300, t);
    ce_n = 1'b1;
    repeat (4) @(negedge clk);
    chk1("abort dq oe", 1'b0, dq_oe);
    chk1("abort flag oe", 1'b0, flag_oe);
    oe_n = 1'b1;
    start_burst(20'h00300, t);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk1("reset dq oe", 1'b0, dq_oe);
    chk1("reset flag oe", 1'b0, flag_oe);
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    read_cfg(16'h9CC4, 1'b1);
  endtask
  // ---------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    read_cfg(16'h9CC4, 1'b1);
    check_cfg_write();
    check_lengths();
    check_latency();
    check_async();
    check_abort();
    finish_test();
  end
  initial
  begin
    #400000;
    miscompares++;
    finish_test();
  end
endmodule
